/* rtl/acc_compare.sv */
// holds the magnitude compare that qualifies a finished conversion
// assumes the sample and settings are stable in the completion cycle
`timescale 1ns/1ps

module acc_compare (
    input  wire logic [acc_pkg::RES_W-1:0] sample_in,
    input  wire acc_pkg::acc_cmp_cfg_t     cfg_in,
    output logic                           accept_out
);

    logic below;

    always_comb begin
        below = sample_in < cfg_in.value;
        if (!cfg_in.enable) begin
            accept_out = 1'b1;
        end else if (cfg_in.ge) begin
            accept_out = !below;
        end else begin
            accept_out = below;
        end
    end

endmodule

/* rtl/acc_control.sv */
// holds the conversion control, status flags, interrupt and wishbone slave
// assumes a single 10 MHz clock and synchronous trigger and sample inputs
//
// The Wishbone interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps

module acc_control #(
    parameter int CONV_CYCLES = 16,
    parameter int CNT_W       = 8
) (
    input  wire logic                          core_clk_in,
    input  wire logic                          reset_n_in,
    input  wire logic                          wb_cyc_in,
    input  wire logic                          wb_stb_in,
    input  wire logic                          wb_we_in,
    input  wire logic [7:0]                    wb_adr_in,
    input  wire logic [3:0]                    wb_sel_in,
    input  wire logic [31:0]                   wb_dat_in,
    output logic      [31:0]                   wb_dat_out,
    output logic                               wb_ack_out,
    input  wire logic                          hardware_trigger_in,
    input  wire logic [acc_pkg::RES_W-1:0]     sample_in,
    output logic                               irq_out,
    output logic                               analog_on_out,
    output logic      [4:0]                    channel_out,
    output logic                               sample_strobe_out
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        acc_pkg::acc_state_t             state;
        logic [CNT_W-1:0]                cnt;
        logic                            conversion_complete_flag;
        logic                            completion_irq_enable;
        logic                            continuous_enable;
        logic [4:0]                      ch;
        logic                            trig;
        logic                            cmp_en;
        logic                            cmp_ge;
        logic                            cont_run;
        logic [acc_pkg::RES_W-1:0]       result;
        logic [acc_pkg::RES_W-1:0]       cmp_val;
        logic [acc_pkg::IRQ_W-1:0]       istat;
        logic [acc_pkg::IRQ_W-1:0]       imask;
        logic                            trig_prev;
        logic                            ack;
        logic [31:0]                     dat;
        logic                            irq;
        logic                            on;
        logic [4:0]                      chan;
        logic                            strobe;
    } acc_regs_t;

    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CONV_CYCLES - 1);

    localparam acc_regs_t REGS_RST = '{
        state:     acc_pkg::ACC_IDLE,
        cnt:       '0,
        conversion_complete_flag: 1'b0,
        completion_irq_enable:    1'b0,
        continuous_enable:        1'b0,
        ch:        acc_pkg::RST_CH,
        trig:      1'b0,
        cmp_en:    1'b0,
        cmp_ge:    1'b0,
        cont_run:  1'b0,
        result:    '0,
        cmp_val:   acc_pkg::RST_CMP,
        istat:     '0,
        imask:     acc_pkg::RST_MASK,
        trig_prev: 1'b0,
        ack:       1'b0,
        dat:       '0,
        irq:       1'b0,
        on:        1'b0,
        chan:      acc_pkg::RST_CH,
        strobe:    1'b0
    };

    acc_regs_t             r_reg;
    acc_regs_t             r_next;
    acc_pkg::acc_cmp_cfg_t cmp_cfg;
    logic                  cmp_accept;
    logic                  access;
    logic                  wr;
    logic                  rd;
    logic                  done;
    logic                  start;
    logic                  hw_edge;
    logic                  ch_valid;
    logic [7:0]            wbyte;

    // ----------------------------------------
    // compare unit
    // ----------------------------------------
    assign cmp_cfg.enable = r_reg.cmp_en;
    assign cmp_cfg.ge     = r_reg.cmp_ge;
    assign cmp_cfg.value  = r_reg.cmp_val;

    acc_compare u_compare (
        .sample_in  (sample_in),
        .cfg_in     (cmp_cfg),
        .accept_out (cmp_accept)
    );

    // ----------------------------------------
    // next-state logic
    // ----------------------------------------
    always_comb begin
        r_next   = r_reg;
        access   = wb_cyc_in && wb_stb_in && !r_reg.ack;
        wr       = access && wb_we_in && wb_sel_in[0];
        rd       = access && !wb_we_in;
        wbyte    = wb_dat_in[7:0];
        hw_edge  = hardware_trigger_in && !r_reg.trig_prev;
        done     = (r_reg.state == acc_pkg::ACC_CONV) && (r_reg.cnt == '0);
        ch_valid = r_reg.ch != acc_pkg::CH_OFF;
        start    = 1'b0;

        r_next.ack       = access;
        r_next.trig_prev = hardware_trigger_in;
        r_next.strobe    = 1'b0;

        // read data; unmapped offsets answer zero
        if (rd) begin
            r_next.dat = 32'h0000_0000;
            case (wb_adr_in)
                acc_pkg::OFS_SC_ONE: begin
                    r_next.dat[acc_pkg::BIT_CPL]             = r_reg.conversion_complete_flag;
                    r_next.dat[acc_pkg::BIT_IEN]             = r_reg.completion_irq_enable;
                    r_next.dat[acc_pkg::BIT_CONT]            = r_reg.continuous_enable;
                    r_next.dat[acc_pkg::CH_HI:acc_pkg::CH_LO] = r_reg.ch;
                end
                acc_pkg::OFS_SC_TWO: begin
                    r_next.dat[acc_pkg::BIT_ACT]   = r_reg.state == acc_pkg::ACC_CONV;
                    r_next.dat[acc_pkg::BIT_TRIG]  = r_reg.trig;
                    r_next.dat[acc_pkg::BIT_CMPEN] = r_reg.cmp_en;
                    r_next.dat[acc_pkg::BIT_CMPGE] = r_reg.cmp_ge;
                end
                acc_pkg::OFS_RESULT: begin
                    r_next.dat[acc_pkg::RES_W-1:0] = r_reg.result;
                    r_next.conversion_complete_flag = 1'b0;
                end
                acc_pkg::OFS_CMP_VAL: begin
                    r_next.dat[acc_pkg::RES_W-1:0] = r_reg.cmp_val;
                end
                acc_pkg::OFS_IRQ_STAT: begin
                    r_next.dat[acc_pkg::IRQ_W-1:0] = r_reg.istat;
                end
                acc_pkg::OFS_IRQ_MASK: begin
                    r_next.dat[acc_pkg::IRQ_W-1:0] = r_reg.imask;
                end
                default: begin
                    r_next.dat = 32'h0000_0000;
                end
            endcase
        end

        // clearing writes come before the hardware sets so a set wins
        if (wr) begin
            case (wb_adr_in)
                acc_pkg::OFS_SC_ONE: begin
                    r_next.conversion_complete_flag = 1'b0;
                end
                acc_pkg::OFS_SC_TWO: begin
                    // reserved low bits are simply not stored
                    r_next.trig   = wbyte[acc_pkg::BIT_TRIG];
                    r_next.cmp_en = wbyte[acc_pkg::BIT_CMPEN];
                    r_next.cmp_ge = wbyte[acc_pkg::BIT_CMPGE];
                    if (!wbyte[acc_pkg::BIT_TRIG]) begin
                        r_next.cont_run = 1'b0;
                    end
                end
                acc_pkg::OFS_CMP_VAL: begin
                    r_next.cmp_val[7:0] = wbyte;
                    if (wb_sel_in[1]) begin
                        r_next.cmp_val[acc_pkg::RES_W-1:8] =
                            wb_dat_in[acc_pkg::RES_W-1:8];
                    end
                end
                acc_pkg::OFS_IRQ_STAT: begin
                    r_next.istat = r_reg.istat & ~wbyte[acc_pkg::IRQ_W-1:0];
                end
                acc_pkg::OFS_IRQ_MASK: begin
                    r_next.imask = wbyte[acc_pkg::IRQ_W-1:0];
                end
                default: begin
                    r_next.imask = r_next.imask;
                end
            endcase
        end

        // ----------------------------------------
        // conversion sequencing
        // ----------------------------------------
        case (r_reg.state)
            acc_pkg::ACC_IDLE: begin
                // triggers landing while busy are dropped
                if (r_reg.trig && hw_edge && ch_valid) begin
                    start = 1'b1;
                    if (r_reg.continuous_enable) begin
                        r_next.cont_run = 1'b1;
                    end
                end
            end
            acc_pkg::ACC_CONV: begin
                if (done) begin
                    r_next.state  = acc_pkg::ACC_IDLE;
                    r_next.strobe = 1'b1;
                    if (cmp_accept) begin
                        r_next.result = sample_in;
                        r_next.conversion_complete_flag = 1'b1;
                        if (r_reg.completion_irq_enable && !r_reg.conversion_complete_flag) begin
                            r_next.istat[acc_pkg::IRQ_DONE] = 1'b1;
                        end
                    end
                    // single mode stops here
                    if (r_reg.continuous_enable && (!r_reg.trig || r_reg.cont_run)) begin
                        start = 1'b1;
                    end
                end else begin
                    r_next.cnt = r_reg.cnt - 1'b1;
                end
            end
            default: begin
                r_next.state = acc_pkg::ACC_IDLE;
            end
        endcase

        // control write overrides the state, start and cont_run the sequencer chose
        if (wr && (wb_adr_in == acc_pkg::OFS_SC_ONE)) begin
            r_next.completion_irq_enable = wbyte[acc_pkg::BIT_IEN];
            r_next.continuous_enable     = wbyte[acc_pkg::BIT_CONT];
            r_next.ch       = wbyte[acc_pkg::CH_HI:acc_pkg::CH_LO];
            r_next.cont_run = 1'b0;
            if ((r_reg.state == acc_pkg::ACC_CONV) && !done) begin
                r_next.istat[acc_pkg::IRQ_ABORT] = 1'b1;
            end
            r_next.state = acc_pkg::ACC_IDLE;
            // all-ones stops without a trailing conversion
            start = (wbyte[acc_pkg::CH_HI:acc_pkg::CH_LO] != acc_pkg::CH_OFF)
                    && !r_reg.trig;
        end

        if (start) begin
            r_next.state = acc_pkg::ACC_CONV;
            r_next.cnt   = CNT_LAST;
        end

        // converter powered only while needed
        r_next.on = (r_next.ch != acc_pkg::CH_OFF)
                    && ((r_next.state == acc_pkg::ACC_CONV)
                        || (r_next.continuous_enable && r_next.trig && r_next.cont_run));
        // channel code passes unchanged to the analog mux only while powered; otherwise the mux gets all-ones
        r_next.chan = r_next.on ? r_next.ch : acc_pkg::CH_OFF;
        r_next.irq  = |(r_next.istat & r_next.imask);
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            r_reg <= REGS_RST;
        end else begin
            r_reg <= r_next;
        end
    end

    assign wb_dat_out        = r_reg.dat;
    assign wb_ack_out        = r_reg.ack;
    assign irq_out           = r_reg.irq;
    assign analog_on_out     = r_reg.on;
    assign channel_out       = r_reg.chan;
    assign sample_strobe_out = r_reg.strobe;

endmodule

/* rtl/acc_pkg.sv */
// holds the shared constants, types and register layout of the converter control block
// assumes a 32-bit classic wishbone slave with byte offsets on word boundaries
package acc_pkg;

    // ----------------------------------------
    // register offsets (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] OFS_SC_ONE   = 8'h00;
    localparam logic [7:0] OFS_SC_TWO   = 8'h04;
    localparam logic [7:0] OFS_RESULT   = 8'h08;
    localparam logic [7:0] OFS_CMP_VAL  = 8'h0c;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h14;

    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int BIT_CPL   = 7;
    localparam int BIT_IEN   = 6;
    localparam int BIT_CONT  = 5;
    localparam int CH_HI     = 4;
    localparam int CH_LO     = 0;
    localparam int BIT_ACT   = 7;
    localparam int BIT_TRIG  = 6;
    localparam int BIT_CMPEN = 5;
    localparam int BIT_CMPGE = 4;
    localparam int IRQ_DONE  = 0;
    localparam int IRQ_ABORT = 1;

    // ----------------------------------------
    // widths and codes
    // ----------------------------------------
    localparam int RES_W = 12;
    localparam int IRQ_W = 2;
    localparam logic [4:0] CH_OFF      = 5'h1f;
    localparam logic [4:0] CH_RESERVED = 5'h1c;
    localparam logic [4:0] CH_REF_HIGH = 5'h1d;
    localparam logic [4:0] CH_REF_LOW  = 5'h1e;
    localparam logic [4:0] CH_EXT_LAST = 5'h1b;

    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [4:0]       RST_CH   = CH_OFF;
    localparam logic [RES_W-1:0] RST_CMP  = 12'h000;
    localparam logic [IRQ_W-1:0] RST_MASK = 2'h0;

    typedef enum logic {
        ACC_IDLE,
        ACC_CONV
    } acc_state_t;

    // compare settings handed to the compare unit
    typedef struct packed {
        logic             enable;
        logic             ge;
        logic [RES_W-1:0] value;
    } acc_cmp_cfg_t;

endpackage

/* test/acc_control_chk.sv */
// concurrent checks on the ports of the converter control block
// assumes it is bound into acc_control and shares its conversion length
`timescale 1ns/1ps

module acc_control_chk #(
    parameter int CONV_CYCLES = 16
) (
    input wire logic        core_clk_in,
    input wire logic        reset_n_in,
    input wire logic        wb_cyc_in,
    input wire logic        wb_stb_in,
    input wire logic        wb_we_in,
    input wire logic [7:0]  wb_adr_in,
    input wire logic [3:0]  wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    input wire logic [31:0] wb_dat_out,
    input wire logic        wb_ack_out,
    input wire logic        hardware_trigger_in,
    input wire logic        analog_on_out,
    input wire logic [4:0]  channel_out,
    input wire logic        sample_strobe_out
);
    localparam int STROBE_DLY = CONV_CYCLES + 1;
    // ----------------------------------------
    // mirror of the mode bits, rebuilt from bus writes
    // ----------------------------------------
    logic       take_w;
    logic       cont_m;
    logic       trig_m;
    logic [4:0] ch_m;
    logic [7:0] sc1_age;
    assign take_w = wb_cyc_in && wb_stb_in && wb_we_in && !wb_ack_out && wb_sel_in[0];
    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            cont_m <= 1'b0;
            trig_m <= 1'b0;
            ch_m   <= acc_pkg::CH_OFF;
        end else if (take_w && wb_adr_in == acc_pkg::OFS_SC_ONE) begin
            cont_m <= wb_dat_in[5];
            ch_m   <= wb_dat_in[4:0];
        end else if (take_w && wb_adr_in == acc_pkg::OFS_SC_TWO) begin
            trig_m <= wb_dat_in[6];
        end
    end
    // cycles since the last control-one write; a later write aborts
    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            sc1_age <= 8'hff;
        end else if (take_w && wb_adr_in == acc_pkg::OFS_SC_ONE) begin
            sc1_age <= 8'h00;
        end else if (sc1_age != 8'hff) begin
            sc1_age <= sc1_age + 8'h01;
        end
    end
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!reset_n_in);
    // ----------------------------------------
    // sequences and properties
    // ----------------------------------------
    sequence s_sc1_write;
        take_w && wb_adr_in == acc_pkg::OFS_SC_ONE;
    endsequence
    sequence s_sw_start;
        s_sc1_write ##0 (!trig_m && wb_dat_in[4:0] != acc_pkg::CH_OFF);
    endsequence
    sequence s_off_write;
        s_sc1_write ##0 (wb_dat_in[4:0] == acc_pkg::CH_OFF);
    endsequence
    property p_ack_delay;
        wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out;
    endproperty
    property p_ack_pulse;
        wb_ack_out |=> !wb_ack_out;
    endproperty
    property p_sw_start;
        s_sw_start |=> analog_on_out && channel_out == ch_m;
    endproperty
    property p_off_write;
        s_off_write |=> (!analog_on_out && channel_out == acc_pkg::CH_OFF)
            ##1 (!sample_strobe_out)[*6];
    endproperty
    property p_single_len;
        s_sw_start ##0 !wb_dat_in[5]
            |-> ##[STROBE_DLY:STROBE_DLY] (sample_strobe_out || sc1_age < 8'(CONV_CYCLES));
    endproperty
    property p_single_sleep;
        sample_strobe_out && !cont_m |-> !analog_on_out;
    endproperty
    property p_cont_rerun;
        sample_strobe_out && cont_m && !trig_m && ch_m != acc_pkg::CH_OFF |-> analog_on_out;
    endproperty
    property p_hw_start;
        $rose(hardware_trigger_in) && trig_m && ch_m != acc_pkg::CH_OFF && !analog_on_out
            |=> analog_on_out;
    endproperty
    property p_unmapped_zero;
        wb_ack_out && !wb_we_in |-> wb_dat_out[31:12] == 20'h0 &&
            (wb_adr_in <= acc_pkg::OFS_IRQ_MASK || wb_dat_out == 32'h0);
    endproperty
    a_ack_delay: assert property (p_ack_delay) else $error("ack late");
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    a_sw_start: assert property (p_sw_start) else $error("no start");
    a_off_write: assert property (p_off_write) else $error("not off");
    a_single_len: assert property (p_single_len) else $error("bad length");
    a_single_sleep: assert property (p_single_sleep) else $error("awake");
    a_cont_rerun: assert property (p_cont_rerun) else $error("no rerun");
    a_hw_start: assert property (p_hw_start) else $error("no hw start");
    a_unmapped_zero: assert property (p_unmapped_zero) else $error("read not zero");
endmodule

bind acc_control acc_control_chk #(.CONV_CYCLES(CONV_CYCLES)) i_acc_control_chk (
    .core_clk_in(core_clk_in), .reset_n_in(reset_n_in), .wb_cyc_in(wb_cyc_in),
    .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
    .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out),
    .wb_ack_out(wb_ack_out), .hardware_trigger_in(hardware_trigger_in),
    .analog_on_out(analog_on_out), .channel_out(channel_out),
    .sample_strobe_out(sample_strobe_out));

/* test/tb_acc_control.sv */
// self-checking bench for the converter control block
// assumes the checker file is compiled alongside and binds itself
`timescale 1ns/1ps

module tb_acc_control;
    localparam int CONV = 4;
    logic        core_clk = 1'b0;
    logic        reset_n  = 1'b0;
    logic        cyc      = 1'b0;
    logic        stb      = 1'b0;
    logic        we       = 1'b0;
    logic [7:0]  adr      = 8'h00;
    logic [3:0]  sel      = 4'h0;
    logic [31:0] wdat     = 32'h0;
    logic        trig     = 1'b0;
    logic [11:0] sample   = 12'h000;
    logic [31:0] rdat;
    logic [31:0] v;
    logic        ack;
    logic        irq;
    logic        aon;
    logic        strobe;
    logic [4:0]  chan;
    int          n_mismatch = 0;
    int          checked    = 0;
    int          n;
    logic [12:0] cmp_tab [4] = '{13'h0200, 13'h1200, 13'h0100, 13'h1100};
    logic        exp_tab [4] = '{1'b1, 1'b0, 1'b0, 1'b1};

    acc_control #(.CONV_CYCLES(CONV)) i_acc_control (
        .core_clk_in(core_clk), .reset_n_in(reset_n), .wb_cyc_in(cyc), .wb_stb_in(stb),
        .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
        .wb_dat_out(rdat), .wb_ack_out(ack), .hardware_trigger_in(trig),
        .sample_in(sample), .irq_out(irq), .analog_on_out(aon), .channel_out(chan),
        .sample_strobe_out(strobe));

    always #50 core_clk = ~core_clk;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic wrap_up();
        $display("mismatches %0d of %0d compares", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one classic cycle; read data lands in v
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        int k;
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        sel  <= 4'hf;
        wdat <= d;
        for (k = 0; k < 20; k++) begin
            @(posedge core_clk);
            if (ack === 1'b1) break;
        end
        v = rdat;
        if (k == 20) begin
            n_mismatch++;
            wrap_up();
        end
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic count(input int cycles);
        n = 0;
        repeat (cycles) begin
            @(posedge core_clk);
            if (strobe === 1'b1) n++;
        end
    endtask

    task automatic pulse_trig();
        trig <= 1'b1;
        @(posedge core_clk);
        trig <= 1'b0;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        repeat (8) @(posedge core_clk);
        reset_n <= 1'b1;
        @(posedge core_clk);
        check(32'(chan), 32'h1f);
        bus(8'h00, 1'b0, 32'h0);
        check(v, 32'h1f);
        bus(8'h20, 1'b1, 32'hff);
        bus(8'h20, 1'b0, 32'h0);
        check(v, 32'h0);
        sample <= 12'h5a5;
        bus(8'h14, 1'b1, 32'h1);
        bus(8'h00, 1'b1, 32'h43);
        bus(8'h04, 1'b0, 32'h0);
        check(v, 32'h80);
        repeat (CONV) @(posedge core_clk);
        bus(8'h00, 1'b0, 32'h0);
        check(v, 32'hc3);
        check(32'(irq), 32'h1);
        bus(8'h08, 1'b0, 32'h0);
        check(v, 32'h5a5);
        bus(8'h00, 1'b0, 32'h0);
        check(v, 32'h43);
        bus(8'h10, 1'b1, 32'h1);
        check(32'(irq), 32'h0);
        bus(8'h00, 1'b1, 32'h02);
        count(CONV + 4);
        check(n, 1);
        check(32'(aon), 32'h0);
        // abort lands one cycle before completion would
        bus(8'h00, 1'b1, 32'h02);
        bus(8'h00, 1'b1, 32'h1f);
        count(CONV + 4);
        check(n, 0);
        bus(8'h10, 1'b0, 32'h0);
        check(v & 32'h2, 32'h2);
        check(32'(irq), 32'h0);
        bus(8'h14, 1'b1, 32'h3);
        check(32'(irq), 32'h1);
        bus(8'h10, 1'b1, 32'h3);
        check(32'(irq), 32'h0);
        bus(8'h00, 1'b1, 32'h22);
        count(3 * CONV + 3);
        check(32'(n >= 2), 32'h1);
        bus(8'h00, 1'b1, 32'h1f);
        count(2 * CONV + 2);
        check(n, 0);
        bus(8'h04, 1'b0, 32'h0);
        check(v, 32'h0);
        sample <= 12'h100;
        for (int i = 0; i < 4; i++) begin
            bus(8'h0c, 1'b1, {20'h0, cmp_tab[i][11:0]});
            bus(8'h04, 1'b1, {26'h0, 1'b1, cmp_tab[i][12], 4'h0});
            bus(8'h00, 1'b1, 32'h01);
            repeat (CONV + 2) @(posedge core_clk);
            bus(8'h00, 1'b0, 32'h0);
            check(32'(v[7]), 32'(exp_tab[i]));
        end
        bus(8'h0c, 1'b0, 32'h0);
        check(v, 32'h100);
        bus(8'h04, 1'b1, 32'h40);
        bus(8'h00, 1'b1, 32'h06);
        count(CONV + 4);
        check(n, 0);
        pulse_trig();
        count(CONV + 4);
        check(n, 1);
        bus(8'h00, 1'b1, 32'h26);
        pulse_trig();
        count(3 * CONV + 3);
        check(32'(n >= 2), 32'h1);
        bus(8'h00, 1'b1, 32'h1f);
        bus(8'h04, 1'b1, 32'h0);
        count(2 * CONV);
        check(n, 0);
        wrap_up();
    end
endmodule
